// file: partition_tag_pkg.sv
package partition_tag_pkg;

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFF_CAPS = 8'h00;
    localparam logic [7:0] OFF_REDIST_SIZE = 8'h04;
    localparam logic [7:0] OFF_XLAT_SIZE = 8'h08;
    localparam logic [7:0] OFF_REDIST_IDCTL = 8'h0c;
    localparam logic [7:0] OFF_XLAT_IDCTL = 8'h10;
    localparam logic [7:0] OFF_CTRL = 8'h14;
    localparam logic [7:0] OFF_XLAT_REQ = 8'h18;
    localparam logic [7:0] OFF_REDIST_ACTIVE = 8'h1c;
    localparam logic [7:0] OFF_XLAT_ACTIVE = 8'h20;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int CAPS_REDIST_BIT = 0;
    localparam int CAPS_XLAT_BIT = 1;
    localparam int CAPS_AFF_LSB = 8;
    localparam int CTRL_MSG_EN_BIT = 0;
    localparam int CTRL_XLAT_EN_BIT = 1;
    localparam int CTRL_SD_BIT = 2;
    localparam int CTRL_NS_SEL_BIT = 3;

    // ****************************************
    // Capabilities and sizes
    // ****************************************
    localparam logic REDIST_SUPPORT = 1'b1;
    localparam logic XLAT_SUPPORT = 1'b1;
    localparam logic [7:0] SHARED_AFFINITY = 8'h01;
    localparam logic [15:0] PART_MAX = 16'h00ff;
    localparam logic [7:0] GROUP_MAX = 8'h03;

    // ****************************************
    // Types and reset values
    // ****************************************
    typedef struct packed {
        logic [7:0] group;
        logic [15:0] part;
    } id_ctl_t;

    typedef enum logic [2:0] {
        TBL_PENDING = 3'h0,
        TBL_CONFIG = 3'h1,
        TBL_VPENDING = 3'h2,
        TBL_VCONFIG = 3'h3,
        TBL_DEVICE = 3'h4,
        TBL_XLATE = 3'h5,
        TBL_COLLECT = 3'h6,
        TBL_VPROC_CMDQ = 3'h7
    } table_kind_t;

    typedef struct packed {
        table_kind_t kind;
        logic [31:0] addr;
    } mem_req_t;

    typedef struct packed {
        logic valid;
        logic ns;
        id_ctl_t id;
        mem_req_t req;
    } tagged_req_t;

    localparam id_ctl_t ID_CTL_RESET = '{group: 8'h00, part: 16'h0000};
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [31:0] XLAT_REQ_RESET = 32'h0000_0000;

endpackage

// file: id_tag_channel.sv
`timescale 1ns/100ps
module id_tag_channel
    import partition_tag_pkg::*;
#(
    parameter logic SUPPORT = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic i_ctl_wr,
    input wire id_ctl_t i_ctl_wdata,
    input wire logic i_enable,
    input wire logic i_sd,
    input wire logic i_ns_sel,
    input wire logic i_req_valid,
    input wire mem_req_t i_req,
    output logic o_req_ready,
    output tagged_req_t o_mem,
    input wire logic i_mem_ready,
    output id_ctl_t o_prog,
    output id_ctl_t o_active
);

    // ****************************************
    // Range handling
    // ****************************************
    // Bad partition drops both fields to defaults, bad group only the group
    function automatic id_ctl_t sanitize(input id_ctl_t v);
        id_ctl_t r;
        r = v;
        if (v.part > PART_MAX) begin
            r = ID_CTL_RESET;
        end else if (v.group > GROUP_MAX) begin
            r.group = ID_CTL_RESET.group;
        end
        return r;
    endfunction

    // ****************************************
    // Request stage
    // ****************************************
    wire logic accept = i_req_valid && o_req_ready;
    wire logic drain = o_mem.valid && i_mem_ready;
    wire logic next_valid = accept || (o_mem.valid && !i_mem_ready);
    wire id_ctl_t tag = SUPPORT ? o_active : ID_CTL_RESET;
    wire logic ns = i_sd ? i_ns_sel : 1'b1;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_prog <= ID_CTL_RESET;
            o_active <= ID_CTL_RESET;
            o_mem <= '0;
            o_req_ready <= 1'b1;
        end else if (i_ce) begin
            if (i_ctl_wr) begin
                o_prog <= sanitize(i_ctl_wdata);
            end
            // Whole word copied at once, frozen while the unit runs
            if (!i_enable) begin
                o_active <= o_prog;
            end
            if (accept) begin
                o_mem <= '{valid: 1'b1, ns: ns, id: tag, req: i_req};
            end else if (drain) begin
                o_mem.valid <= 1'b0;
            end
            o_req_ready <= !next_valid;
        end
    end

endmodule

// file: partition_tag_top.sv
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/100ps

module partition_tag_top
    import partition_tag_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_redist_req_valid,
    input wire mem_req_t i_redist_req,
    output logic o_redist_req_ready,
    output tagged_req_t o_redist_mem,
    input wire logic i_redist_mem_ready,
    input wire logic i_xlat_req_valid,
    input wire mem_req_t i_xlat_req,
    output logic o_xlat_req_ready,
    output tagged_req_t o_xlat_mem,
    input wire logic i_xlat_mem_ready
);

    // ****************************************
    // Control state
    // ****************************************
    logic [3:0] ctrl;
    logic [31:0] xlat_req_value;
    id_ctl_t redist_prog;
    id_ctl_t redist_active;
    id_ctl_t xlat_prog;
    id_ctl_t xlat_active;

    wire logic message_interrupt_enable = ctrl[CTRL_MSG_EN_BIT];
    wire logic xlat_unit_enable = ctrl[CTRL_XLAT_EN_BIT];
    wire logic security_disable = ctrl[CTRL_SD_BIT];
    wire logic ns_select = ctrl[CTRL_NS_SEL_BIT];

    // ****************************************
    // Write decode
    // ****************************************
    wire logic wr_redist_ctl = i_wr && (i_addr == OFF_REDIST_IDCTL);
    wire logic wr_xlat_ctl = i_wr && (i_addr == OFF_XLAT_IDCTL);
    wire logic wr_ctrl = i_wr && (i_addr == OFF_CTRL);
    wire logic wr_xlat_req = i_wr && (i_addr == OFF_XLAT_REQ) && xlat_unit_enable;
    wire id_ctl_t ctl_wdata = id_ctl_t'(i_wdata[23:0]);

    // ****************************************
    // Read decode
    // ****************************************
    wire logic [31:0] caps_value = {16'h0000, SHARED_AFFINITY, 6'h00, XLAT_SUPPORT, REDIST_SUPPORT};
    wire logic [31:0] size_value = {8'h00, GROUP_MAX, PART_MAX};
    wire logic [31:0] read_value =
        (i_addr == OFF_CAPS) ? caps_value :
        (i_addr == OFF_REDIST_SIZE) ? size_value :
        (i_addr == OFF_XLAT_SIZE) ? size_value :
        (i_addr == OFF_REDIST_IDCTL) ? {8'h00, redist_prog} :
        (i_addr == OFF_XLAT_IDCTL) ? {8'h00, xlat_prog} :
        (i_addr == OFF_CTRL) ? {28'h0000000, ctrl} :
        (i_addr == OFF_XLAT_REQ) ? xlat_req_value :
        (i_addr == OFF_REDIST_ACTIVE) ? {8'h00, redist_active} :
        (i_addr == OFF_XLAT_ACTIVE) ? {8'h00, xlat_active} :
        32'h0000_0000;

    // ****************************************
    // Register file
    // ****************************************
    // With i_ce high, read data stands one cycle only, zero otherwise; i_ce low holds it
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            ctrl <= CTRL_RESET;
            xlat_req_value <= XLAT_REQ_RESET;
            o_rdata <= 32'h0000_0000;
        end else if (i_ce) begin
            if (wr_ctrl) begin
                ctrl <= i_wdata[3:0];
            end
            if (wr_xlat_req) begin
                xlat_req_value <= i_wdata;
            end
            o_rdata <= i_rd ? read_value : 32'h0000_0000;
        end
    end

    // ****************************************
    // Tagging channels
    // ****************************************
    // Redistributor id control is kept private even when the affinity
    // field groups redistributors; sharing would need a system-level path
    id_tag_channel #(
        .SUPPORT(REDIST_SUPPORT)
    ) u_redist (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_ctl_wr(wr_redist_ctl),
        .i_ctl_wdata(ctl_wdata),
        .i_enable(message_interrupt_enable),
        .i_sd(security_disable),
        .i_ns_sel(ns_select),
        .i_req_valid(i_redist_req_valid),
        .i_req(i_redist_req),
        .o_req_ready(o_redist_req_ready),
        .o_mem(o_redist_mem),
        .i_mem_ready(i_redist_mem_ready),
        .o_prog(redist_prog),
        .o_active(redist_active)
    );

    // Tags only leave the block; nothing inside is partitioned by them
    id_tag_channel #(
        .SUPPORT(XLAT_SUPPORT)
    ) u_xlat (
        .i_clk(i_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_ctl_wr(wr_xlat_ctl),
        .i_ctl_wdata(ctl_wdata),
        .i_enable(xlat_unit_enable),
        .i_sd(security_disable),
        .i_ns_sel(ns_select),
        .i_req_valid(i_xlat_req_valid),
        .i_req(i_xlat_req),
        .o_req_ready(o_xlat_req_ready),
        .o_mem(o_xlat_mem),
        .i_mem_ready(i_xlat_mem_ready),
        .o_prog(xlat_prog),
        .o_active(xlat_active)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    wire logic redist_accept = i_ce && i_redist_req_valid && o_redist_req_ready;
    wire logic xlat_accept = i_ce && i_xlat_req_valid && o_xlat_req_ready;

    sequence s_redist_take;
        redist_accept;
    endsequence

    sequence s_xlat_take;
        xlat_accept;
    endsequence

    property p_ns_forced;
        s_redist_take and !security_disable |=> o_redist_mem.valid && o_redist_mem.ns;
    endproperty
    a_ns_forced: assert property (p_ns_forced) else $error("ns not forced");

    property p_ns_select;
        s_xlat_take and security_disable |=> o_xlat_mem.ns == $past(ns_select);
    endproperty
    a_ns_select: assert property (p_ns_select) else $error("ns select lost");

    property p_caps_redist;
        i_ce && i_rd && i_addr == OFF_CAPS |=> o_rdata[CAPS_REDIST_BIT] == REDIST_SUPPORT;
    endproperty
    a_caps_redist: assert property (p_caps_redist) else $error("caps redist bit");

    property p_caps_xlat;
        i_ce && i_rd && i_addr == OFF_CAPS |=> o_rdata[CAPS_XLAT_BIT] == XLAT_SUPPORT
            && o_rdata[CAPS_AFF_LSB +: 8] == SHARED_AFFINITY;
    endproperty
    a_caps_xlat: assert property (p_caps_xlat) else $error("caps xlat bits");

    property p_size;
        i_ce && i_rd && (i_addr == OFF_REDIST_SIZE || i_addr == OFF_XLAT_SIZE)
            |=> o_rdata == {8'h00, GROUP_MAX, PART_MAX};
    endproperty
    a_size: assert property (p_size) else $error("size report wrong");

    property p_part_oor;
        i_ce && wr_redist_ctl && ctl_wdata.part > PART_MAX |=> redist_prog == ID_CTL_RESET;
    endproperty
    a_part_oor: assert property (p_part_oor) else $error("bad partition kept");

    property p_group_oor;
        i_ce && wr_xlat_ctl && ctl_wdata.part <= PART_MAX && ctl_wdata.group > GROUP_MAX
            |=> xlat_prog.group == ID_CTL_RESET.group && xlat_prog.part == $past(ctl_wdata.part);
    endproperty
    a_group_oor: assert property (p_group_oor) else $error("bad group kept");

    property p_pickup;
        i_ce && !message_interrupt_enable ##1 i_ce && message_interrupt_enable
            |-> redist_active == $past(redist_prog);
    endproperty
    a_pickup: assert property (p_pickup) else $error("id not picked up");

    property p_atomic;
        i_ce && xlat_unit_enable |=> $stable(xlat_active);
    endproperty
    a_atomic: assert property (p_atomic) else $error("active id moved");

    property p_redist_tag;
        s_redist_take |=> o_redist_mem.id == $past(redist_active);
    endproperty
    a_redist_tag: assert property (p_redist_tag) else $error("redist tag wrong");

    property p_xlat_tag;
        s_xlat_take |=> o_xlat_mem.id == $past(xlat_active)
            && o_xlat_mem.req == $past(i_xlat_req);
    endproperty
    a_xlat_tag: assert property (p_xlat_tag) else $error("xlat tag wrong");

    property p_xlat_req_ignored;
        i_wr && i_addr == OFF_XLAT_REQ && !xlat_unit_enable |=> $stable(xlat_req_value);
    endproperty
    a_xlat_req_ignored: assert property (p_xlat_req_ignored) else $error("write not ignored");

    property p_hold;
        o_redist_mem.valid && !(i_ce && i_redist_mem_ready) |=> $stable(o_redist_mem);
    endproperty
    a_hold: assert property (p_hold) else $error("request not held");

    property p_hold_x;
        o_xlat_mem.valid && !(i_ce && i_xlat_mem_ready) |=> $stable(o_xlat_mem);
    endproperty
    a_hold_x: assert property (p_hold_x) else $error("xlat request not held");

    property p_read_once;
        i_ce && !i_rd |=> o_rdata == 32'h0000_0000;
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data lingers");

endmodule

// file: mem_sink_model.sv
`timescale 1ns/100ps
// ****************************************
// Interconnect sink model
// ****************************************
module mem_sink_model
    import partition_tag_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [1:0] i_wait,
    input wire tagged_req_t i_mem,
    output logic o_ready,
    output logic o_took,
    output tagged_req_t o_taken,
    output logic o_unstable
);
    logic [1:0] cnt;
    tagged_req_t held;
    // Slow answers stretch the hold window, so a drifting tag gets caught
    assign o_ready = i_mem.valid && (cnt == i_wait);
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            cnt <= 2'h0;
            held <= '0;
            o_took <= 1'b0;
            o_taken <= '0;
            o_unstable <= 1'b0;
        end else begin
            held <= i_mem;
            cnt <= (i_mem.valid && !o_ready) ? cnt + 2'h1 : 2'h0;
            o_took <= o_ready;
            if (o_ready) begin
                o_taken <= i_mem;
            end
            if (held.valid && cnt != 2'h0 && i_mem !== held) begin
                o_unstable <= 1'b1;
            end
        end
    end
endmodule

// file: tb_memory_partition_id_tagging.sv
`timescale 1ns/100ps
module tb_memory_partition_id_tagging;
    import partition_tag_pkg::*;
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic rv = 1'b0;
    logic xv = 1'b0;
    mem_req_t rr = '0;
    mem_req_t xr = '0;
    logic r_rdy, x_rdy, rm_rdy, xm_rdy, r_took, x_took, r_bad, x_bad;
    tagged_req_t r_mem, x_mem, r_taken, x_taken;
    logic [1:0] r_wait = 2'h0;
    logic [1:0] x_wait = 2'h0;
    int fails = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] got;

    always #10 i_clk = ~i_clk;

    partition_tag_top partition_tag_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_redist_req_valid(rv),
        .i_redist_req(rr), .o_redist_req_ready(r_rdy), .o_redist_mem(r_mem), .i_redist_mem_ready(rm_rdy),
        .i_xlat_req_valid(xv), .i_xlat_req(xr), .o_xlat_req_ready(x_rdy), .o_xlat_mem(x_mem),
        .i_xlat_mem_ready(xm_rdy));
    mem_sink_model sink_r_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_wait(r_wait), .i_mem(r_mem),
        .o_ready(rm_rdy), .o_took(r_took), .o_taken(r_taken), .o_unstable(r_bad));
    mem_sink_model sink_x_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_wait(x_wait), .i_mem(x_mem),
        .o_ready(xm_rdy), .o_took(x_took), .o_taken(x_taken), .o_unstable(x_bad));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] seen);
        checks_done++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            fails++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(posedge i_clk);
        chk(what, {4'h0, exp}, {4'h0, o_rdata});
    endtask

    // Hands one request to a channel, then judges what the sink took
    task automatic send(input logic ch, input table_kind_t k, input logic [1:0] wt, input logic [24:0] exp);
        mem_req_t r;
        tagged_req_t t;
        int n;
        r = '{kind: k, addr: 32'h0000_a000 + 32'(k)};
        @(posedge i_clk);
        if (ch) begin
            x_wait <= wt;
            xv <= 1'b1;
            xr <= r;
        end else begin
            r_wait <= wt;
            rv <= 1'b1;
            rr <= r;
        end
        for (n = 0; n < 8; n++) begin
            @(posedge i_clk);
            if (ch ? x_rdy : r_rdy) break;
        end
        xv <= 1'b0;
        rv <= 1'b0;
        @(posedge i_clk);
        chk("busy", 36'h0, {35'h0, ch ? x_rdy : r_rdy});
        for (n = 0; n < 8; n++) begin
            @(posedge i_clk);
            if (ch ? x_took : r_took) break;
        end
        t = ch ? x_taken : r_taken;
        chk("free", 36'h1, {35'h0, ch ? x_rdy : r_rdy});
        chk("ns_id", {11'h0, exp}, {11'h0, t.ns, t.id});
        chk("req", {1'b0, r}, {1'b0, t.req});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_caps();
        rd_chk("caps", OFF_CAPS, 32'h0000_0103);
        rd_chk("rsize", OFF_REDIST_SIZE, 32'h0003_00ff);
        wr(OFF_XLAT_SIZE, 32'h0);
        rd_chk("xsize", OFF_XLAT_SIZE, 32'h0003_00ff);
        rd_chk("ctrl", OFF_CTRL, 32'h0);
        rd_chk("unmapped", 8'h24, 32'h0);
        $display("test caps done");
    endtask

    task automatic t_idctl();
        logic [7:0] offs [2] = '{OFF_REDIST_IDCTL, OFF_XLAT_IDCTL};
        foreach (offs[i]) begin
            rd_chk("idctl_rst", offs[i], 32'h0);
            wr(offs[i], 32'h0003_00ff);
            rd_chk("idctl", offs[i], 32'h0003_00ff);
            wr(offs[i], 32'h0001_0100);
            rd_chk("part_oor", offs[i], 32'h0);
            wr(offs[i], 32'h0004_00aa);
            rd_chk("group_oor", offs[i], 32'h0000_00aa);
        end
        $display("test idctl done");
    endtask

    task automatic t_effect();
        wr(OFF_REDIST_IDCTL, 32'h0001_0011);
        wr(OFF_XLAT_IDCTL, 32'h0002_0022);
        rd_chk("ractive", OFF_REDIST_ACTIVE, 32'h0001_0011);
        wr(OFF_CTRL, 32'h3);
        // Rewrite while enabled on purpose: the old word must stay whole
        wr(OFF_REDIST_IDCTL, 32'h0003_0033);
        wr(OFF_XLAT_IDCTL, 32'h0001_0044);
        for (int k = 0; k < 4; k++) begin
            send(1'b0, table_kind_t'(k), 2'(k), 25'h101_0011);
            send(1'b1, table_kind_t'(k + 4), 2'(k), 25'h102_0022);
        end
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h3);
        rd_chk("xactive", OFF_XLAT_ACTIVE, 32'h0001_0044);
        send(1'b0, TBL_VCONFIG, 2'h3, 25'h103_0033);
        send(1'b1, TBL_VPROC_CMDQ, 2'h0, 25'h101_0044);
        $display("test effect done");
    endtask

    task automatic t_ns();
        wr(OFF_CTRL, 32'h7);
        send(1'b0, TBL_PENDING, 2'h1, 25'h003_0033);
        send(1'b1, TBL_DEVICE, 2'h2, 25'h001_0044);
        wr(OFF_CTRL, 32'hf);
        send(1'b0, TBL_CONFIG, 2'h0, 25'h103_0033);
        $display("test ns done");
    endtask

    task automatic t_xreq();
        wr(OFF_CTRL, 32'h0);
        wr(OFF_XLAT_REQ, 32'hcafe_0001);
        rd_chk("xreq_off", OFF_XLAT_REQ, 32'h0);
        wr(OFF_CTRL, 32'h2);
        wr(OFF_XLAT_REQ, 32'h1234_5678);
        rd_chk("xreq_on", OFF_XLAT_REQ, 32'h1234_5678);
        chk("stable", 36'h0, {34'h0, r_bad, x_bad});
        $display("test xreq done");
    endtask

    // A write with the clock enable low must leave the old word whole
    task automatic t_freeze();
        @(posedge i_clk);
        i_ce <= 1'b0;
        wr(OFF_REDIST_IDCTL, 32'h0002_0055);
        @(posedge i_clk);
        i_ce <= 1'b1;
        rd_chk("frozen", OFF_REDIST_IDCTL, 32'h0003_0033);
        $display("test freeze done");
    endtask

    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge i_clk);
        i_nrst <= 1'b1;
        t_caps();
        t_idctl();
        t_effect();
        t_ns();
        t_xreq();
        t_freeze();
        complete_run();
    end
endmodule
